// *** src/dsr_defs.svh ***
// Constants for the DDR3 self refresh controller and device model
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// ----------------------------------------------------------------
// Clock and conversion
// ----------------------------------------------------------------
`define DSR_CLK_NS 50
`define DSR_CYC_UP(t) (((t) + `DSR_CLK_NS - 1) / `DSR_CLK_NS)
`define DSR_TW 10

// ----------------------------------------------------------------
// Self refresh timing
// ----------------------------------------------------------------
`define DSR_T_RP_NS 15
`define DSR_T_CKE_NS 5
`define DSR_T_CKSRE_NS 10
`define DSR_T_CKSRX_NS 10
`define DSR_T_XS_NS 170
`define DSR_T_XSDLL_CK 512
`define DSR_T_ZQOPER_CK 256
`define DSR_VREF_WR_CK 512
`define DSR_T_RP_CYC `DSR_CYC_UP(`DSR_T_RP_NS)
`define DSR_T_CKESR_CYC (`DSR_CYC_UP(`DSR_T_CKE_NS) + 1)
`define DSR_T_CKSRE_CYC `DSR_CYC_UP(`DSR_T_CKSRE_NS)
`define DSR_T_CKSRX_CYC `DSR_CYC_UP(`DSR_T_CKSRX_NS)
`define DSR_T_XS_CYC `DSR_CYC_UP(`DSR_T_XS_NS)
`define DSR_XSDLL_REST (`DSR_T_XSDLL_CK - `DSR_T_XS_CYC)
`define DSR_ZQ_WAIT_CYC ((`DSR_XSDLL_REST > `DSR_T_ZQOPER_CK) ? `DSR_XSDLL_REST : `DSR_T_ZQOPER_CK)

// ----------------------------------------------------------------
// Refresh period
// ----------------------------------------------------------------
`define DSR_REF_ROWS 8192
`define DSR_REF_MS_NORM 64
`define DSR_REF_MS_HOT 32
`define DSR_TREFI_CYC(ms) (((ms) * 1000000) / `DSR_REF_ROWS / `DSR_CLK_NS)

// ----------------------------------------------------------------
// Mode register 2 fields
// ----------------------------------------------------------------
`define DSR_MR2_BA 3'h2
`define DSR_MR2_ASR_BIT 6
`define DSR_MR2_SRT_BIT 7
`define DSR_A10_BIT 10

// ----------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------
`define DSR_REG_CTRL 4'h0
`define DSR_REG_STATUS 4'h4
`define DSR_REG_CMD 4'h8
`define DSR_CTRL_ENTER 0
`define DSR_CTRL_EXIT 1
`define DSR_CTRL_ASR 2
`define DSR_CTRL_SRT 3
`define DSR_CTRL_CLKALT 4
`define DSR_CTRL_VREF 5
`define DSR_CTRL_HOT 6
`define DSR_CTRL_ODT 7

`endif

// *** src/dsr_device.sv ***
// DDR3 device end: self refresh entry, exit and mode register 2 options
`include "dsr_defs.svh"
module dsr_device (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Link
    dsr_if.device link,
    // Status
    output logic in_sr_out,
    output logic dll_on_out,
    output logic dll_reset_out,
    output logic int_refresh_out,
    output logic ext_refresh_out,
    output logic [1:0] sr_range_out,
    output logic xs_met_out,
    output logic xsdll_met_out
);
    localparam dsr_pkg::dsr_dev_t RST = '{st: dsr_pkg::DSR_DEV_IDLE, dll_on: 1'b1,
        dll_rst: 1'b0, int_ref: 1'b0, ext_ref: 1'b0, ref_cnt: '0, auto_rate_self_refresh_bit: 1'b0, extended_temp_self_refresh_bit: 1'b0,
        xs_cnt: `DSR_TW'(`DSR_T_XSDLL_CK), xs_met: 1'b1, xsdll_met: 1'b1};

    dsr_pkg::dsr_dev_t q;
    dsr_pkg::dsr_dev_t d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.dll_rst = 1'b0;
        d.int_ref = 1'b0;
        d.ext_ref = 1'b0;
        if (!link.rst_n)
        begin
            d = RST;
        end
        else
        begin
            case (q.st)
                dsr_pkg::DSR_DEV_IDLE:
                begin
                    // Exit intervals counted from first high edge
                    if (q.xs_cnt < `DSR_TW'(`DSR_T_XSDLL_CK))
                    begin
                        d.xs_cnt = q.xs_cnt + `DSR_TW'(1);
                    end
                    if (link.cmd == dsr_pkg::DSR_CMD_REF && !link.cke)
                    begin
                        d.st = dsr_pkg::DSR_DEV_SR;
                        d.dll_on = 1'b0;
                        d.ref_cnt = '0;
                    end
                    else if (link.cmd == dsr_pkg::DSR_CMD_REF)
                    begin
                        d.ext_ref = 1'b1;
                    end
                    else if (link.cmd == dsr_pkg::DSR_CMD_MRS && link.ba == `DSR_MR2_BA)
                    begin
                        d.auto_rate_self_refresh_bit = link.addr[`DSR_MR2_ASR_BIT];
                        d.extended_temp_self_refresh_bit = link.addr[`DSR_MR2_SRT_BIT];
                    end
                end
                dsr_pkg::DSR_DEV_SR:
                begin
                    // only CKE and reset looked at
                    if (link.cke)
                    begin
                        d.st = dsr_pkg::DSR_DEV_IDLE;
                        d.xs_cnt = `DSR_TW'(1);
                        // DLL on and reset at exit
                        d.dll_on = 1'b1;
                        d.dll_rst = 1'b1;
                    end
                    else if (q.ref_cnt == '0)
                    begin
                        d.int_ref = 1'b1;
                        d.ref_cnt = (q.auto_rate_self_refresh_bit || q.extended_temp_self_refresh_bit) ?
                            `DSR_TW'(`DSR_TREFI_CYC(`DSR_REF_MS_HOT) - 1) :
                            `DSR_TW'(`DSR_TREFI_CYC(`DSR_REF_MS_NORM) - 1);
                    end
                    else
                    begin
                        d.ref_cnt = q.ref_cnt - `DSR_TW'(1);
                    end
                end
                default:
                begin
                    d = RST;
                end
            endcase
            if (d.st == dsr_pkg::DSR_DEV_SR)
            begin
                d.xs_cnt = '0;
            end
            d.xs_met = (d.xs_cnt >= `DSR_TW'(`DSR_T_XS_CYC));
            d.xsdll_met = (d.xs_cnt >= `DSR_TW'(`DSR_T_XSDLL_CK));
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            q <= RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign in_sr_out = (q.st == dsr_pkg::DSR_DEV_SR);
    assign dll_on_out = q.dll_on;
    assign dll_reset_out = q.dll_rst;
    assign int_refresh_out = q.int_ref;
    assign ext_refresh_out = q.ext_ref;
    assign sr_range_out = {q.auto_rate_self_refresh_bit, q.extended_temp_self_refresh_bit};
    assign xs_met_out = q.xs_met;
    assign xsdll_met_out = q.xsdll_met;
endmodule

// *** src/dsr_host.sv ***
// Memory controller end: refresh, self refresh entry and exit, bus registers
//
// Contract
// - Entry is REFRESH with CKE registered low
// - Device DLL off in, on and reset out
// - Floated reference: first WRITE 512 clocks later
// - All banks precharged, tRP met before entry
// - ODT registered low before entry command
// - CKE held low throughout self refresh
// - Device ignores all but CKE, RESET#
// - Device refreshes internally within tCKE
// - Stable clock: CKE high after tCKESR
// - Altered clock: tCKSRE after, tCKSRX before
// - Only NOP or DES during tXS
// - ZQCL, tZQoper, tXSDLL; ODT off meanwhile
// - NOP after entry and before exit
// - Exit async; intervals from first high edge
// - Hot case doubles external refresh rate
// - Hot without AUTO_RATE_SELF_REFRESH_BIT or EXTENDED_TEMP_SELF_REFRESH_BIT: no entry
// - MR2 bit 7 selects manual range
// - MR2 bit 6 enables automatic rate
// - Manual bit zero when automatic bit set
`include "dsr_defs.svh"
module dsr_host (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Link
    dsr_if.host link
);
    localparam dsr_pkg::dsr_host_t RST = '{st: dsr_pkg::DSR_H_INIT, cke: 1'b1, odt: 1'b0,
        rst_n: 1'b0, cmd: dsr_pkg::DSR_CMD_NOP, ba: '0, addr: '0, enter_p: 1'b0,
        exit_p: 1'b0, auto_rate_self_refresh_bit: 1'b0, extended_temp_self_refresh_bit: 1'b0, clk_alter: 1'b0, vref_float: 1'b0, hot: 1'b0,
        odt_req: 1'b0, mr2_dirty: 1'b0, clk_ok: 1'b0, ack: 1'b0, rdata: '0,
        ref_cnt: `DSR_TW'(`DSR_TREFI_CYC(`DSR_REF_MS_NORM) - 1), ref_due: 1'b0};
    dsr_pkg::dsr_host_t q;
    dsr_pkg::dsr_host_t d;
    logic [`DSR_TW-1:0] tmr_val;
    logic tmr_ld, tmr_done, vtmr_ld, vtmr_done, req, cmd_req, cmd_ok;
    logic blocked, write_ok, ctrl_wr;
    // ------------------------------------------------------------
    // Wait timers
    // ------------------------------------------------------------
    // rounded waits counted down
    dsr_wait_timer u_state_timer (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .load_in(tmr_ld),
        .count_in(tmr_val),
        .done_out(tmr_done)
    );
    dsr_wait_timer u_vref_timer (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .load_in(vtmr_ld),
        .count_in(`DSR_TW'(`DSR_VREF_WR_CK)),
        .done_out(vtmr_done)
    );
    // Request decode
    assign req = avs_read_in || avs_write_in;
    assign cmd_req = avs_write_in && (avs_address_in == `DSR_REG_CMD);
    assign ctrl_wr = avs_write_in && q.ack && (avs_address_in == `DSR_REG_CTRL);
    // WRITE held until reference wait done
    assign write_ok = vtmr_done;
    assign cmd_ok = (avs_writedata_in[2:0] != dsr_pkg::DSR_CMD_WRITE) || write_ok;
    // hot without either option blocks entry
    assign blocked = q.hot && !q.auto_rate_self_refresh_bit && !q.extended_temp_self_refresh_bit;
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        tmr_ld = 1'b0;
        tmr_val = '0;
        vtmr_ld = 1'b0;
        d.cmd = dsr_pkg::DSR_CMD_NOP;
        d.ba = '0;
        d.addr = '0;
        d.ack = 1'b0;
        d.rst_n = 1'b1;
        // Register reads and plain writes answer one cycle later
        if (req && !q.ack && !cmd_req)
        begin
            d.ack = 1'b1;
            case (avs_address_in)
                `DSR_REG_CTRL:
                    d.rdata = {24'h000000, q.odt_req, q.hot, q.vref_float, q.clk_alter,
                        q.extended_temp_self_refresh_bit, q.auto_rate_self_refresh_bit, q.exit_p, q.enter_p};
                `DSR_REG_STATUS:
                    d.rdata = {23'h000000, q.ref_due, q.enter_p, blocked, q.clk_ok,
                        write_ok, (q.st == dsr_pkg::DSR_H_SR), q.st};
                default:
                    d.rdata = 32'h00000000;
            endcase
        end
        if (ctrl_wr)
        begin
            d.enter_p = q.enter_p || avs_writedata_in[`DSR_CTRL_ENTER];
            d.exit_p = q.exit_p || avs_writedata_in[`DSR_CTRL_EXIT];
            d.auto_rate_self_refresh_bit = avs_writedata_in[`DSR_CTRL_ASR];
            d.extended_temp_self_refresh_bit = avs_writedata_in[`DSR_CTRL_SRT];
            d.clk_alter = avs_writedata_in[`DSR_CTRL_CLKALT];
            d.vref_float = avs_writedata_in[`DSR_CTRL_VREF];
            d.hot = avs_writedata_in[`DSR_CTRL_HOT];
            d.odt_req = avs_writedata_in[`DSR_CTRL_ODT];
            d.mr2_dirty = q.mr2_dirty || (d.auto_rate_self_refresh_bit != q.auto_rate_self_refresh_bit) || (d.extended_temp_self_refresh_bit != q.extended_temp_self_refresh_bit);
        end
        // interval halves when hot; zero cycle counts
        if (q.ref_cnt == '0)
        begin
            d.ref_due = 1'b1;
            d.ref_cnt = q.hot ? `DSR_TW'(`DSR_TREFI_CYC(`DSR_REF_MS_HOT) - 1) :
                `DSR_TW'(`DSR_TREFI_CYC(`DSR_REF_MS_NORM) - 1);
        end
        else
            d.ref_cnt = q.ref_cnt - `DSR_TW'(1);
        case (q.st)
            dsr_pkg::DSR_H_INIT:
            begin
                d.cmd = dsr_pkg::DSR_CMD_MRS;
                d.ba = `DSR_MR2_BA;
                d.addr[`DSR_MR2_ASR_BIT] = q.auto_rate_self_refresh_bit;
                d.addr[`DSR_MR2_SRT_BIT] = q.extended_temp_self_refresh_bit && !q.auto_rate_self_refresh_bit;
                d.mr2_dirty = 1'b0;
                d.st = dsr_pkg::DSR_H_IDLE;
            end
            dsr_pkg::DSR_H_IDLE:
            begin
                if (cmd_req && cmd_ok)
                begin
                    if (q.ack)
                    begin
                        d.cmd = dsr_pkg::dsr_cmd_t'(avs_writedata_in[2:0]);
                        d.ba = avs_writedata_in[5:3];
                        d.addr = avs_writedata_in[31:16];
                    end
                    else
                        d.ack = 1'b1;
                end
                else if (q.ref_due)
                begin
                    d.cmd = dsr_pkg::DSR_CMD_REF;
                    d.ref_due = 1'b0;
                end
                else if (q.mr2_dirty)
                    d.st = dsr_pkg::DSR_H_INIT;
                else if (q.enter_p && !blocked)
                begin
                    d.cmd = dsr_pkg::DSR_CMD_PRE;
                    d.addr[`DSR_A10_BIT] = 1'b1;
                    tmr_ld = 1'b1;
                    tmr_val = `DSR_TW'(`DSR_T_RP_CYC);
                    d.st = dsr_pkg::DSR_H_PRE;
                end
            end
            dsr_pkg::DSR_H_PRE:
            begin
                if (tmr_done)
                begin
                    d.cmd = dsr_pkg::DSR_CMD_REF;
                    d.cke = 1'b0;
                    // A request written in this same cycle survives
                    d.enter_p = ctrl_wr && avs_writedata_in[`DSR_CTRL_ENTER];
                    d.exit_p = ctrl_wr && avs_writedata_in[`DSR_CTRL_EXIT];
                    tmr_ld = 1'b1;
                    tmr_val = q.clk_alter ? `DSR_TW'(`DSR_T_CKSRE_CYC) :
                        `DSR_TW'(`DSR_T_CKESR_CYC);
                    d.st = dsr_pkg::DSR_H_SR;
                end
            end
            dsr_pkg::DSR_H_SR:
            begin
                d.cke = 1'b0;
                d.ref_cnt = q.ref_cnt;
                d.ref_due = 1'b0;
                d.clk_ok = tmr_done && q.clk_alter;
                if (tmr_done && q.exit_p)
                begin
                    d.exit_p = ctrl_wr && avs_writedata_in[`DSR_CTRL_EXIT];
                    d.clk_ok = 1'b0;
                    tmr_ld = 1'b1;
                    if (q.clk_alter)
                    begin
                        // stable clock tCKSRX before CKE high
                        tmr_val = `DSR_TW'(`DSR_T_CKSRX_CYC);
                        d.st = dsr_pkg::DSR_H_SRX;
                    end
                    else
                    begin
                        d.cke = 1'b1;
                        tmr_val = `DSR_TW'(`DSR_T_XS_CYC);
                        vtmr_ld = q.vref_float;
                        d.st = dsr_pkg::DSR_H_XS;
                    end
                end
            end
            dsr_pkg::DSR_H_SRX:
            begin
                d.cke = 1'b0;
                if (tmr_done)
                begin
                    d.cke = 1'b1;
                    tmr_ld = 1'b1;
                    tmr_val = `DSR_TW'(`DSR_T_XS_CYC);
                    vtmr_ld = q.vref_float;
                    d.st = dsr_pkg::DSR_H_XS;
                end
            end
            dsr_pkg::DSR_H_XS:
            begin
                if (tmr_done)
                begin
                    d.cmd = dsr_pkg::DSR_CMD_ZQCL;
                    tmr_ld = 1'b1;
                    tmr_val = `DSR_TW'(`DSR_ZQ_WAIT_CYC);
                    d.ref_cnt = '0;
                    d.st = dsr_pkg::DSR_H_ZQ;
                end
            end
            dsr_pkg::DSR_H_ZQ:
                if (tmr_done)
                    d.st = dsr_pkg::DSR_H_IDLE;
            default:
                d.st = dsr_pkg::DSR_H_INIT;
        endcase
        d.odt = d.odt_req && (d.st == dsr_pkg::DSR_H_IDLE) && (q.st == dsr_pkg::DSR_H_IDLE);
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            q <= RST;
        else
            q <= d;
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata_out = q.rdata;
    assign avs_waitrequest_out = req && !q.ack;
    assign link.cke = q.cke;
    assign link.odt = q.odt;
    assign link.rst_n = q.rst_n;
    assign link.cmd = q.cmd;
    assign link.ba = q.ba;
    assign link.addr = q.addr;
endmodule

// *** src/dsr_if.sv ***
// Link between the memory controller and the DDR3 device
interface dsr_if;
    logic cke;
    logic rst_n;
    logic odt;
    dsr_pkg::dsr_cmd_t cmd;
    logic [2:0] ba;
    logic [15:0] addr;

    modport host (output cke, rst_n, odt, cmd, ba, addr);
    modport device (input cke, rst_n, odt, cmd, ba, addr);
endinterface

// *** src/dsr_pkg.sv ***
// Types shared by both ends of the self refresh link
`include "dsr_defs.svh"
package dsr_pkg;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DSR_CMD_NOP = 3'h0,
        DSR_CMD_DES = 3'h1,
        DSR_CMD_REF = 3'h2,
        DSR_CMD_PRE = 3'h3,
        DSR_CMD_ZQCL = 3'h4,
        DSR_CMD_WRITE = 3'h5,
        DSR_CMD_READ = 3'h6,
        DSR_CMD_MRS = 3'h7
    } dsr_cmd_t;

    typedef enum logic [1:0] {
        DSR_DEV_IDLE = 2'h0,
        DSR_DEV_SR = 2'h1
    } dsr_dev_st_t;

    typedef enum logic [2:0] {
        DSR_H_INIT = 3'h0,
        DSR_H_IDLE = 3'h1,
        DSR_H_PRE = 3'h2,
        DSR_H_SR = 3'h3,
        DSR_H_SRX = 3'h4,
        DSR_H_XS = 3'h5,
        DSR_H_ZQ = 3'h6
    } dsr_host_st_t;

    // ------------------------------------------------------------
    // Module state records
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`DSR_TW-1:0] cnt;
        logic done;
    } dsr_tmr_t;

    typedef struct packed {
        dsr_dev_st_t st;
        logic dll_on;
        logic dll_rst;
        logic int_ref;
        logic ext_ref;
        logic [`DSR_TW-1:0] ref_cnt;
        logic auto_rate_self_refresh_bit;
        logic extended_temp_self_refresh_bit;
        logic [`DSR_TW-1:0] xs_cnt;
        logic xs_met;
        logic xsdll_met;
    } dsr_dev_t;

    typedef struct packed {
        dsr_host_st_t st;
        logic cke;
        logic odt;
        logic rst_n;
        dsr_cmd_t cmd;
        logic [2:0] ba;
        logic [15:0] addr;
        logic enter_p;
        logic exit_p;
        logic auto_rate_self_refresh_bit;
        logic extended_temp_self_refresh_bit;
        logic clk_alter;
        logic vref_float;
        logic hot;
        logic odt_req;
        logic mr2_dirty;
        logic clk_ok;
        logic ack;
        logic [31:0] rdata;
        logic [`DSR_TW-1:0] ref_cnt;
        logic ref_due;
    } dsr_host_t;

endpackage

// *** src/dsr_wait_timer.sv ***
// Down counter that flags when a loaded wait has elapsed
`include "dsr_defs.svh"
module dsr_wait_timer (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Load
    input wire logic load_in,
    input wire logic [`DSR_TW-1:0] count_in,
    // Status
    output logic done_out
);
    dsr_pkg::dsr_tmr_t q;
    dsr_pkg::dsr_tmr_t d;

    // Next count
    always_comb
    begin
        d = q;
        if (load_in)
        begin
            d.cnt = count_in;
        end
        else if (q.cnt != '0)
        begin
            d.cnt = q.cnt - `DSR_TW'(1);
        end
        d.done = (d.cnt == '0);
    end

    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            q <= '{cnt: '0, done: 1'b1};
        end
        else
        begin
            q <= d;
        end
    end

    assign done_out = q.done;
endmodule

// *** verification/ddr3_self_refresh_control_test.sv ***
// Testbench joining controller and device over the self refresh link
module ddr3_self_refresh_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in;
    logic nrst_in;
    logic [3:0] adr;
    logic rd_en, wr_en, wreq, in_sr, dll_on, dll_rst, int_ref, ext_ref, xs_met, xsdll_met;
    logic [31:0] wdat, rdat, v;
    logic [1:0] rng;
    int miscompares = 0, checks = 0, n_int = 0, n_rst = 0, cyc = 0, t_prev = 0, t_last = 0;
    dsr_if u_dsr_if ();
    dsr_host u_dsr_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .avs_address_in(adr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .link(u_dsr_if));
    dsr_device u_dsr_device (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .link(u_dsr_if),
        .in_sr_out(in_sr), .dll_on_out(dll_on), .dll_reset_out(dll_rst),
        .int_refresh_out(int_ref), .ext_refresh_out(ext_ref), .sr_range_out(rng),
        .xs_met_out(xs_met), .xsdll_met_out(xsdll_met));
    dsr_link_sva u_dsr_link_sva (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cke(u_dsr_if.cke),
        .rst_n(u_dsr_if.rst_n), .odt(u_dsr_if.odt), .cmd(u_dsr_if.cmd), .ba(u_dsr_if.ba),
        .addr(u_dsr_if.addr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk_sys_in);
        while (wreq !== 1'b0) @(posedge clk_sys_in);
        v = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    // Polls the host state field
    task automatic wait_st(input logic [2:0] s);
        repeat (400)
        begin
            bus(1'b0, 4'h4, 32'h0);
            if (v[2:0] === s)
                return;
        end
        chk(v[2:0], s);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Clock, 50 ns period
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Pulse counts and refresh spacing
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (int_ref === 1'b1)
            n_int++;
        if (dll_rst === 1'b1)
            n_rst++;
        if (ext_ref === 1'b1)
        begin
            t_prev = t_last;
            t_last = cyc;
        end
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        nrst_in = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        adr = 4'h0;
        wdat = 32'h0;
        repeat (20) @(posedge clk_sys_in);
        chk({in_sr, dll_on, rng, xs_met, xsdll_met}, 32'h13);
        nrst_in <= 1'b1;
        bus(1'b0, 4'hc, 32'h0);
        chk(v, 32'h0);
        repeat (400) @(posedge clk_sys_in);
        chk(t_last - t_prev, 156);
        bus(1'b1, 4'h0, 32'h40);
        repeat (400) @(posedge clk_sys_in);
        chk(t_last - t_prev, 78);
        bus(1'b1, 4'h0, 32'h41);
        repeat (50) @(posedge clk_sys_in);
        bus(1'b0, 4'h4, 32'h0);
        chk({v[6], in_sr}, 32'h2);
        bus(1'b1, 4'h0, 32'h45);
        wait_st(3'h3);
        repeat (2) @(posedge clk_sys_in);
        chk({rng, dll_on, in_sr, xs_met}, 32'h12);
        chk(n_int > 0, 32'h1);
        bus(1'b1, 4'h0, 32'h46);
        wait_st(3'h1);
        chk({in_sr, dll_on, xs_met, xsdll_met}, 32'h7);
        bus(1'b1, 4'h0, 32'h4c);
        repeat (20) @(posedge clk_sys_in);
        chk(rng, 32'h2);
        bus(1'b1, 4'h0, 32'h88);
        repeat (20) @(posedge clk_sys_in);
        chk(rng, 32'h1);
        bus(1'b1, 4'h0, 32'h99);
        wait_st(3'h3);
        bus(1'b0, 4'h4, 32'h0);
        chk({v[5], v[3]}, 32'h3);
        bus(1'b1, 4'h0, 32'h9a);
        wait_st(3'h1);
        chk(n_rst, 32'h2);
        bus(1'b1, 4'h0, 32'h21);
        wait_st(3'h3);
        bus(1'b1, 4'h0, 32'h22);
        wait_st(3'h6);
        chk(v[4], 32'h0);
        wait_st(3'h1);
        bus(1'b1, 4'h8, 32'h5);
        bus(1'b0, 4'h4, 32'h0);
        chk(v[4], 32'h1);
        end_of_test();
    end
endmodule

// *** verification/dsr_link_sva.sv ***
// Protocol checker for the self refresh link
module dsr_link_sva (
    // Clock, reset and link signals
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic cke,
    input wire logic rst_n,
    input wire logic odt,
    input wire logic [2:0] cmd,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr
);
    logic cke_q;
    logic [9:0] xs_q;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence entry_s;
        cmd == dsr_pkg::DSR_CMD_REF && !cke;
    endsequence
    sequence sr_idle_s;
        cmd == dsr_pkg::DSR_CMD_NOP && !cke;
    endsequence
    // Cycles left of the DLL relock window
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cke_q <= 1'b1;
            xs_q <= 10'h0;
        end
        else
        begin
            cke_q <= cke;
            xs_q <= (cke && !cke_q) ? 10'h1ff : ((xs_q != 10'h0) ? xs_q - 10'h1 : xs_q);
        end
    end
    entry_with_ref_a: assert property ($fell(cke) |-> entry_s)
        else $error("clock enable fell without refresh");
    prech_first_a: assert property ($fell(cke) |-> $past(cmd, 2) == dsr_pkg::DSR_CMD_PRE && $past(addr[10], 2))
        else $error("entry without all-bank precharge");
    odt_low_entry_a: assert property ($fell(cke) |-> !odt && !$past(odt))
        else $error("termination on at entry");
    entry_nop_a: assert property (entry_s |=> sr_idle_s)
        else $error("no idle command after entry");
    cke_min_low_a: assert property ($fell(cke) |-> !cke [*2])
        else $error("exit before minimum low time");
    sr_nop_only_a: assert property (!cke && !$past(cke) |-> cmd == dsr_pkg::DSR_CMD_NOP)
        else $error("command during self refresh");
    xs_nop_a: assert property ($rose(cke) |-> (cmd == dsr_pkg::DSR_CMD_NOP) [*4])
        else $error("command inside exit wait");
    zq_after_exit_a: assert property ($rose(cke) |-> ##[4:8] cmd == dsr_pkg::DSR_CMD_ZQCL)
        else $error("no calibration after exit");
    odt_xsdll_a: assert property (xs_q != 10'h0 |-> !odt && cmd != dsr_pkg::DSR_CMD_READ && cmd != dsr_pkg::DSR_CMD_WRITE)
        else $error("termination or access before relock");
    mr2_after_rst_a: assert property ($rose(rst_n) |-> cmd == dsr_pkg::DSR_CMD_MRS && ba == 3'h2)
        else $error("no mode register 2 write after reset");
    mr2_legal_a: assert property (cmd == dsr_pkg::DSR_CMD_MRS && ba == 3'h2 |-> !(addr[6] && addr[7]))
        else $error("illegal refresh option pair");
endmodule
